// ===== rtl/sms_port.sv
`timescale 1ns/1ps
// How it works
// R1: master_select one makes the port master
// R2: only the master starts a transfer
// R3: write loads shifter, read returns buffer
// R4: master data write starts full-duplex byte
// R5: shift out MOSI, shift in MISO
// R6: after eight bits set flag, buffer byte
// R7: software clears flag, then reads byte
// R8: master_select zero: clock, select become inputs
// R9: slave idle until select driven low
// R10: master holds select low whole byte
// R11: fault_detect_disable matters only as master
// R12: disable zero: select pin is fault input
// R13: disable one: select follows output enable
// R14: slave shifts on external clock, flags after eight
module sms_port #(
  parameter logic [7:0] CLK_DIV = sms_pkg::CLK_DIV_DEF
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic master_select_i,
  input wire logic fault_detect_disable_i,
  input wire logic select_output_enable_i,
  input wire logic flag_clear_i,
  output logic transfer_done_flag_o,
  output logic mode_fault_o,
  sms_link_if.dev link
);
  typedef enum logic [1:0] {SMS_IDLE, SMS_SHIFT, SMS_END} sms_state_e;
  sms_state_e state_r;
  logic [7:0] tx_r;
  logic [7:0] rd_buf_r;
  logic [7:0] div_r;
  logic [3:0] cnt_r;
  logic sck_r;
  logic ss_n_r;
  logic busy_r;
  logic smp_r;
  logic miso_s1_r;
  logic miso_s2_r;
  logic ss_s1_r;
  logic ss_s2_r;
  logic [7:0] lk_sh_r;
  logic [7:0] lk_byte_r;
  logic [2:0] lk_cnt_r;
  logic lk_tog_r;
  logic tg1_r;
  logic tg2_r;
  logic tg3_r;
  logic wr_hit;
  logic rd_hit;
  logic start_go;
  logic tick;
  logic slave_done;
  logic fault_on;

  // One decode for both directions keeps read and write on the same address
  function automatic logic is_data_addr(input logic [7:0] addr);
    return addr == sms_pkg::SHIFT_DATA_OFS;
  endfunction

  assign wr_hit = reg_wr_i && is_data_addr(reg_addr_i);
  assign rd_hit = reg_rd_i && is_data_addr(reg_addr_i);
  assign start_go = (state_r == SMS_IDLE) && wr_hit && master_select_i;
  assign tick = (div_r == CLK_DIV);
  assign slave_done = tg2_r ^ tg3_r;
  assign fault_on = master_select_i && !fault_detect_disable_i; // R11 R12

  assign link.dev_sck_o = sck_r;
  assign link.dev_sck_oe = master_select_i; // R8
  assign link.dev_mosi_o = tx_r[7];
  assign link.dev_mosi_oe = master_select_i;
  assign link.dev_ss_n_o = ss_n_r;
  assign link.dev_ss_n_oe = master_select_i && fault_detect_disable_i
                            && select_output_enable_i; // R13
  // The first bit must stand on the line before the master's first rising edge
  assign link.miso_o = (lk_cnt_r == 3'h0) ? tx_r[7] : lk_sh_r[7]; // R14
  assign link.miso_oe = !master_select_i && !link.ss_n; // R14

  // Two-flop synchronisers for link pins read by the system clock
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else if (clk_en_i) begin
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ss_s1_r <= 1'b1;
      ss_s2_r <= 1'b1;
    end else if (clk_en_i) begin
      ss_s1_r <= link.ss_n;
      ss_s2_r <= ss_s1_r;
    end
  end

  // Byte-done toggle from the link clock; only the second and third flops are compared
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tg1_r <= 1'b0;
      tg2_r <= 1'b0;
      tg3_r <= 1'b0;
    end else if (clk_en_i) begin
      tg1_r <= lk_tog_r;
      tg2_r <= tg1_r;
      tg3_r <= tg2_r;
    end
  end

  // Half-period divider, restarted at a start so the first edge is a full half period away
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= 8'h00_00;
    end else if (clk_en_i) begin
      if (start_go) begin
        div_r <= 8'h00_00;
      end else begin
        div_r <= tick ? 8'h00_00 : div_r + 8'h00_01;
      end
    end
  end

  // Master engine: sample on the rising edge, move data on the falling edge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= SMS_IDLE;
      tx_r <= sms_pkg::SHIFT_DATA_RST;
      cnt_r <= 4'h0_0;
      sck_r <= 1'b0;
      ss_n_r <= 1'b1;
      busy_r <= 1'b0;
      smp_r <= 1'b0;
    end else if (clk_en_i) begin
      case (state_r)
        SMS_IDLE: begin
          if (wr_hit) begin
            tx_r <= reg_wdata_i; // R3
            if (master_select_i) begin // R1 R2 R4
              ss_n_r <= 1'b0;
              busy_r <= 1'b1;
              cnt_r <= 4'h0_0;
              state_r <= SMS_SHIFT;
            end
          end
        end
        SMS_SHIFT: begin
          if (tick) begin
            sck_r <= !sck_r;
            if (!sck_r) begin
              // The slave's bit has stood for a full period, less the two-flop synchroniser delay
              smp_r <= miso_s2_r; // R5
            end else begin
              // MOSI only moves here, so it is steady at every rising edge
              tx_r <= {tx_r[6:0], smp_r}; // R5
              if (cnt_r == sms_pkg::BIT_CNT_LAST) begin
                state_r <= SMS_END;
              end else begin
                cnt_r <= cnt_r + 4'h0_1;
              end
            end
          end
        end
        SMS_END: begin
          ss_n_r <= 1'b1;
          busy_r <= 1'b0;
          state_r <= SMS_IDLE;
        end
        default: state_r <= SMS_IDLE;
      endcase
    end
  end

  // Completion flag and read buffer; a new completion beats a clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      transfer_done_flag_o <= 1'b0;
      rd_buf_r <= sms_pkg::SHIFT_DATA_RST;
    end else if (clk_en_i) begin
      if (state_r == SMS_END) begin
        transfer_done_flag_o <= 1'b1; // R6
        rd_buf_r <= tx_r; // R6
      end else if (slave_done && !master_select_i) begin
        transfer_done_flag_o <= 1'b1; // R14
        rd_buf_r <= lk_byte_r;
      end else if (flag_clear_i) begin
        transfer_done_flag_o <= 1'b0; // R7
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00_00;
    end else if (clk_en_i) begin
      reg_rdata_o <= rd_hit ? rd_buf_r : 8'h00_00; // R3
    end
  end

  // Another master pulling select low while we are master and not busy
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_fault_o <= 1'b0;
    end else if (clk_en_i) begin
      mode_fault_o <= fault_on && !ss_s2_r && !busy_r; // R12
    end
  end

  // Slave shifter on the link clock. tx_r is only rewritten between frames, so it is
  // quasi-static here; lk_byte_r holds for a whole byte after the toggle, far longer
  // than the three-flop crossing needs.
  always_ff @(posedge link.sck or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lk_sh_r <= 8'h00_00;
      lk_cnt_r <= 3'h0;
      lk_byte_r <= 8'h00_00;
      lk_tog_r <= 1'b0;
    end else if (!master_select_i && !link.ss_n) begin // R9
      lk_sh_r <= {(lk_cnt_r == 3'h0 ? tx_r[6:0] : lk_sh_r[6:0]), link.mosi}; // R14
      lk_cnt_r <= lk_cnt_r + 3'h1;
      if (lk_cnt_r == sms_pkg::BIT_CNT_LAST[2:0]) begin
        lk_byte_r <= {lk_sh_r[6:0], link.mosi};
        lk_tog_r <= !lk_tog_r;
      end
    end
  end
endmodule

// ===== rtl/sms_pkg.sv
package sms_pkg;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] SHIFT_DATA_OFS = 8'h00_F5;
  localparam logic [7:0] SHIFT_DATA_RST = 8'h00_00;
  localparam int unsigned FDD_BIT = 3;
  localparam logic [3:0] BIT_CNT_LAST = 4'h0_7;
  localparam logic [7:0] CLK_DIV_DEF = 8'h00_04;
endpackage

// ===== rtl/sms_link_if.sv
`timescale 1ns/1ps
interface sms_link_if;
  logic sck_o;
  logic sck_oe;
  logic ss_n_o;
  logic ss_n_oe;
  logic mosi_o;
  logic mosi_oe;
  logic miso_o;
  logic miso_oe;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_ss_n_o;
  logic dev_ss_n_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic far_miso_o;
  logic far_miso_oe;
  wire logic sck = dev_sck_oe ? dev_sck_o : (sck_oe ? sck_o : 1'b0);
  wire logic ss_n = dev_ss_n_oe ? dev_ss_n_o : (ss_n_oe ? ss_n_o : 1'b1);
  wire logic mosi = dev_mosi_oe ? dev_mosi_o : (mosi_oe ? mosi_o : 1'b0);
  wire logic miso = miso_oe ? miso_o : (far_miso_oe ? far_miso_o : 1'b0);
  modport dev (
    input sck, ss_n, mosi, miso,
    output dev_sck_o, dev_sck_oe, dev_ss_n_o, dev_ss_n_oe, dev_mosi_o, dev_mosi_oe,
    output miso_o, miso_oe
  );
  modport far (
    input sck, ss_n, mosi, miso,
    output sck_o, sck_oe, ss_n_o, ss_n_oe, mosi_o, mosi_oe, far_miso_o, far_miso_oe
  );
endinterface

// ===== rtl/sms_far_end.sv
`timescale 1ns/1ps
// Partner device: master (divided clock) or slave (on the link clock)
module sms_far_end #(
  parameter logic [7:0] CLK_DIV = sms_pkg::CLK_DIV_DEF
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic far_master_i,
  input wire logic start_i,
  input wire logic [7:0] tx_byte_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_byte_o,
  sms_link_if.far link
);
  typedef enum logic [1:0] {FAR_IDLE, FAR_SEL, FAR_SHIFT, FAR_END} sms_far_state_e;
  sms_far_state_e state_r;
  logic [7:0] div_r, sh_r;
  logic [3:0] cnt_r;
  logic sck_r, ss_n_r, miso_s1_r, miso_s2_r, smp_r;
  logic [7:0] slv_sh_r;
  logic [2:0] slv_cnt_r;
  logic slv_tog_r, slv_t1_r, slv_t2_r, slv_t3_r;
  logic [7:0] slv_byte_r;
  logic tick;
  logic slv_done;

  assign tick = (div_r == CLK_DIV);
  assign slv_done = slv_t2_r ^ slv_t3_r;
  assign link.sck_o = sck_r;
  assign link.sck_oe = far_master_i;
  assign link.ss_n_o = ss_n_r;
  assign link.ss_n_oe = far_master_i;
  assign link.mosi_o = sh_r[7];
  assign link.mosi_oe = far_master_i;
  // First bit stands on the line before the master's first rising edge
  assign link.far_miso_o = (slv_cnt_r == 3'h0) ? tx_byte_i[7] : slv_sh_r[7];
  assign link.far_miso_oe = !far_master_i && !link.ss_n;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else if (clk_en_i) begin
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // Master side: only this end starts a transfer, select held low throughout
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= FAR_IDLE;
      div_r <= 8'h00_00;
      sh_r <= 8'h00_00;
      cnt_r <= 4'h0_0;
      sck_r <= 1'b0;
      smp_r <= 1'b0;
      ss_n_r <= 1'b1;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rx_byte_o <= 8'h00_00;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      div_r <= tick ? 8'h00_00 : div_r + 8'h00_01;
      case (state_r)
        FAR_IDLE: begin
          if (start_i && far_master_i) begin // R2
            sh_r <= tx_byte_i;
            ss_n_r <= 1'b0; // R10
            busy_o <= 1'b1;
            cnt_r <= 4'h0_0;
            state_r <= FAR_SEL;
          end else if (slv_done && !far_master_i) begin
            done_o <= 1'b1;
            rx_byte_o <= slv_byte_r;
          end
        end
        FAR_SEL: if (tick) state_r <= FAR_SHIFT;
        FAR_SHIFT: begin
          if (tick) begin
            sck_r <= !sck_r;
            if (!sck_r) begin
              smp_r <= miso_s2_r;
            end else begin
              // Data moves only on the falling edge
              sh_r <= {sh_r[6:0], smp_r};
              if (cnt_r == sms_pkg::BIT_CNT_LAST) begin
                state_r <= FAR_END;
              end else begin
                cnt_r <= cnt_r + 4'h0_1;
              end
            end
          end
        end
        FAR_END: begin
          if (tick) begin
            ss_n_r <= 1'b1; // R10
            busy_o <= 1'b0;
            done_o <= 1'b1;
            rx_byte_o <= sh_r;
            state_r <= FAR_IDLE;
          end
        end
        default: state_r <= FAR_IDLE;
      endcase
    end
  end

  // Slave side on the link clock; shifts only while selected
  always_ff @(posedge link.sck or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slv_sh_r <= 8'h00_00;
      slv_cnt_r <= 3'h0;
      slv_tog_r <= 1'b0;
      slv_byte_r <= 8'h00_00;
    end else if (!far_master_i && !link.ss_n) begin // R9
      slv_sh_r <= {(slv_cnt_r == 3'h0 ? tx_byte_i[6:0] : slv_sh_r[6:0]), link.mosi};
      slv_cnt_r <= slv_cnt_r + 3'h1;
      if (slv_cnt_r == sms_pkg::BIT_CNT_LAST[2:0]) begin
        slv_byte_r <= {slv_sh_r[6:0], link.mosi};
        slv_tog_r <= !slv_tog_r;
      end
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slv_t1_r <= 1'b0;
      slv_t2_r <= 1'b0;
      slv_t3_r <= 1'b0;
    end else if (clk_en_i) begin
      slv_t1_r <= slv_tog_r;
      slv_t2_r <= slv_t1_r;
      slv_t3_r <= slv_t2_r;
    end
  end
endmodule

// ===== sim/sms_link_properties.sv
`timescale 1ns/1ps
module sms_link_properties (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic master_select_i,
  input wire logic fault_detect_disable_i,
  input wire logic select_output_enable_i,
  input wire logic flag_clear_i,
  input wire logic transfer_done_flag_o,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic dev_sck_oe,
  input wire logic dev_ss_n_oe,
  input wire logic miso_oe
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_rise;
    master_select_i && $rose(sck);
  endsequence
  sequence s_idle2;
    (!master_select_i && ss_n) [*2];
  endsequence
  AST_SLAVE_SCK_IN: assert property (!master_select_i |-> !dev_sck_oe)
    else $error("slave drives the clock pin");
  AST_SLAVE_SS_IN: assert property (!master_select_i |-> !dev_ss_n_oe)
    else $error("slave drives the select pin");
  AST_SLAVE_QUIET: assert property (s_idle2 |-> !miso_oe)
    else $error("unselected slave drives data");
  AST_FAULT_INPUT: assert property (master_select_i && !fault_detect_disable_i
    |-> !dev_ss_n_oe)
    else $error("select pin driven while fault detect on");
  AST_SS_FOLLOWS_OE: assert property (master_select_i && fault_detect_disable_i
    && !select_output_enable_i |-> !dev_ss_n_oe)
    else $error("select pin driven with output enable off");
  AST_EDGE_IN_FRAME: assert property (s_rise |-> !ss_n)
    else $error("clock edge outside a frame");
  AST_MOSI_STABLE: assert property (s_rise |-> $stable(mosi))
    else $error("data moved at the sampling edge");
  AST_FLAG_STICKY: assert property (transfer_done_flag_o && !flag_clear_i
    |=> transfer_done_flag_o)
    else $error("flag dropped without a clear");
  AST_FLAG_AT_END: assert property (master_select_i && $rose(transfer_done_flag_o) |-> ss_n)
    else $error("flag raised inside a frame");
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock_i = 0, arst_n_i = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, far_tx = 0, far_rx, rd;
  logic reg_wr = 0, reg_rd = 0, master_sel = 0, fdd = 0, soe = 0, flag_clr = 0;
  logic flag, mfault, far_master = 0, far_start = 0, far_busy, far_done;
  int n_errors = 0, checks_done = 0;
  sms_link_if link();
  sms_port sms_port_i(.clock_i(clock_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .master_select_i(master_sel), .fault_detect_disable_i(fdd),
    .select_output_enable_i(soe), .flag_clear_i(flag_clr), .transfer_done_flag_o(flag),
    .mode_fault_o(mfault), .link(link));
  sms_far_end sms_far_end_i(.clock_i(clock_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .far_master_i(far_master), .start_i(far_start), .tx_byte_i(far_tx),
    .busy_o(far_busy), .done_o(far_done), .rx_byte_o(far_rx), .link(link));
  sms_link_properties sms_link_properties_i(.clock_i(clock_i), .arst_n_i(arst_n_i),
    .master_select_i(master_sel), .fault_detect_disable_i(fdd), .select_output_enable_i(soe),
    .flag_clear_i(flag_clr), .transfer_done_flag_o(flag), .sck(link.sck), .ss_n(link.ss_n),
    .mosi(link.mosi), .dev_sck_oe(link.dev_sck_oe), .dev_ss_n_oe(link.dev_ss_n_oe),
    .miso_oe(link.miso_oe));
  always #2 clock_i = ~clock_i;
  task step;
    @(posedge clock_i);
    #1;
  endtask
  task wrap_up;
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    step;
    reg_wr = 0;
    step;
  endtask
  task reg_read(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1;
    step;
    reg_rd = 0;
    rd = reg_rdata;
    step;
  endtask
  // Far side done is a one-cycle pulse, so it is polled every cycle
  task wait_ev(input bit far);
    for (int i = 0; i < 600; i++) begin
      if ((far ? far_done : flag) === 1'b1) return;
      step;
    end
    n_errors++;
    wrap_up;
  endtask
  task clear_flag;
    flag_clr = 1;
    step;
    flag_clr = 0;
    step;
  endtask
  task far_go(input logic [7:0] b);
    far_tx = b;
    far_start = 1;
    step;
    far_start = 0;
  endtask
  task t_master(input logic [7:0] tx, input logic [7:0] rx);
    master_sel = 1; fdd = 1; soe = 1; far_master = 0; far_tx = rx;
    step;
    reg_write(8'h00_F5, tx);
    reg_write(8'h00_F5, ~tx);
    wait_ev(0);
    reg_read(8'h00_F5);
    check(rd, rx);
    check(far_rx, tx);
    clear_flag;
    check({7'h00, flag}, 8'h00_00);
  endtask
  task t_slave;
    master_sel = 0;
    reg_write(8'h00_F5, 8'h00_5A);
    far_master = 1;
    far_go(8'h00_C3);
    wait_ev(1);
    check(far_rx, 8'h00_5A);
    wait_ev(0);
    reg_read(8'h00_F5);
    check(rd, 8'h00_C3);
    clear_flag;
  endtask
  task t_fault(input logic ms, input logic dis, input logic exp);
    master_sel = ms; fdd = dis; soe = 0; far_master = 1;
    far_go(8'h00_81);
    for (int i = 0; i < 50 && link.ss_n !== 1'b0; i++) step;
    check({7'h00, link.ss_n}, 8'h00_00);
    repeat (4) step;
    check({7'h00, mfault}, {7'h00, exp});
    wait_ev(1);
    repeat (4) step;
    clear_flag;
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    #1 arst_n_i = 1;
    step;
    reg_read(8'h00_F5);
    check(rd, 8'h00_00);
    reg_read(8'h00_F4);
    check(rd, 8'h00_00);
    t_master(8'h00_A5, 8'h00_3C);
    t_master(8'h00_00, 8'h00_FF);
    t_slave;
    t_fault(1, 0, 1);
    t_fault(1, 1, 0);
    t_fault(0, 0, 0);
    wrap_up;
  end
endmodule
